// >>> design/dnc_params.svh
// Register indices, field positions and reset values for the down-converter config block
`ifndef DNC_PARAMS_SVH
`define DNC_PARAMS_SVH
`define DNC_IDX_DECIM_CTRL   12'h330
`define DNC_IDX_INPUT_SEL    12'h331
`define DNC_IDX_OSC_CTRL     12'h334
`define DNC_IDX_CHAN_SEL     12'h314
`define DNC_IDX_STATUS       12'h3F0
`define DNC_RST_DECIM_CTRL   8'h00
`define DNC_RST_INPUT_SEL    8'h05
`define DNC_RST_OSC_CTRL     8'h00
`define DNC_RST_CHAN_SEL     8'h00
`define DNC_BIT_C2R          3
`define DNC_BIT_QSRC         2
`define DNC_BIT_ISRC         0
`define DNC_PRIMARY_EXT      3'h7
`define DNC_INPUT_SEL_MASK   8'hF5
`endif

// >>> design/dnc_pkg.sv
// Types shared by the down-converter config block
package dnc_pkg;
  // Index source modes
  typedef enum logic [3:0] {
    DNC_MODE_REG  = 4'h0,
    DNC_MODE_B0A0 = 4'h1,
    DNC_MODE_B1A1 = 4'h2,
    DNC_MODE_A1A0 = 4'h3,
    DNC_MODE_B1B0 = 4'h4,
    DNC_MODE_MIXA = 4'h5,
    DNC_MODE_MIXB = 4'h6,
    DNC_MODE_EA0  = 4'h8,
    DNC_MODE_EA1  = 4'h9,
    DNC_MODE_EB0  = 4'hA
  } dnc_mode_e;
  // Filter stages enabled in the chain
  typedef struct packed {
    logic fifth_band_stage;
    logic third_band_stage_two;
    logic third_band_stage_one;
    logic half_band_stage_four;
    logic half_band_stage_three;
    logic half_band_stage_two;
    logic half_band_stage_one;
  } dnc_chain_s;
  // Decoded decimation setting
  typedef struct packed {
    dnc_chain_s chain;
    logic [5:0] factor;
    logic       bad;
  } dnc_decim_s;
endpackage : dnc_pkg

// >>> design/dnc_top.sv
// Second down-converter decimation, input select and oscillator index selection
`timescale 1ns/10ps
`include "dnc_params.svh"

// Behaviour
// - Extended code 0: third-band two plus half-bands four..one, by 48 or 24.
// - Extended code 2: fifth-band plus half-band one, by 10 or 5.
// - Extended code 3: fifth-band, half-bands two and one, by 20 or 10.
// - Extended code 4: fifth-band, half-bands three..one, by 40 or 20.
// - Extended code 7: third-band one alone, by 3; real output unsupported.
// - Extended code 8: fifth-band plus third-band one, by 15; real unsupported.
// - Extended code 9: half-band two, fifth, third-band one, by 30; real unsupported.
// - Mode 0 takes the index from the channel select register field.
// - Modes 1 and 2: zeros, pin B then pin A, bit0 or bit1 pins.
// - Mode 3 uses A bit1,A bit0; mode 4 uses B bit1,B bit0, zero-extended.
// - Mode 5 interleaves all four pins as b1,a1,b0,a0; mode 6 takes them in order b1,b0,a1,a0.
// - Modes 8,9,10 count rising edges of A bit0, A bit1, B bit0.
// - Edge counter wraps to zero after reaching the programmed limit.
// - Extended code applies only when the primary select is 7.
// - Real-output enable halves the decimation factor and gives I only.
module dnc_top (
  input  wire logic               clock,
  input  wire logic               arst_n,
  input  wire logic [11:0]        address,
  input  wire logic               read,
  input  wire logic               write,
  input  wire logic [3:0]         byteenable,
  input  wire logic [31:0]        writedata,
  output logic      [31:0]        readdata,
  output logic                    waitrequest,
  input  wire logic               select_pin_a_bit0,
  input  wire logic               select_pin_a_bit1,
  input  wire logic               select_pin_b_bit0,
  input  wire logic               select_pin_b_bit1,
  output logic      [3:0]         active_channel,
  output dnc_pkg::dnc_decim_s     decim_cfg,
  output logic                    real_output,
  output logic                    quad_path_source,
  output logic                    inphase_path_source
);

  // ****************************************
  // Decimation decode
  // ****************************************

  function automatic dnc_pkg::dnc_decim_s decode(input logic [2:0] prim, input logic [3:0] ext,
                                                 input logic c2r);
    dnc_pkg::dnc_decim_s d;
    logic [5:0]          cx;
    d  = '0;
    cx = 6'h00;
    unique case (prim)
      3'h0: begin d.chain = 7'h03; cx = 6'h04; end
      3'h1: begin d.chain = 7'h07; cx = 6'h08; end
      3'h2: begin d.chain = 7'h0F; cx = 6'h10; end
      3'h3: begin d.chain = 7'h01; cx = 6'h02; end
      3'h4: begin d.chain = 7'h21; cx = 6'h06; end
      3'h5: begin d.chain = 7'h23; cx = 6'h0C; end
      3'h6: begin d.chain = 7'h27; cx = 6'h18; end
      3'h7:
      begin
        unique case (ext)
          4'h0: begin d.chain = 7'h2F; cx = 6'h30; end
          4'h2: begin d.chain = 7'h41; cx = 6'h0A; end
          4'h3: begin d.chain = 7'h43; cx = 6'h14; end
          4'h4: begin d.chain = 7'h47; cx = 6'h28; end
          4'h7: begin d.chain = 7'h10; cx = 6'h03; d.bad = c2r; end
          4'h8: begin d.chain = 7'h50; cx = 6'h0F; d.bad = c2r; end
          4'h9: begin d.chain = 7'h52; cx = 6'h1E; d.bad = c2r; end
          default: d.bad = 1'b1;
        endcase
      end
    endcase
    d.factor = (c2r && !d.bad) ? (cx >> 1) : (d.bad ? 6'h00 : cx);
    if (d.bad)
    begin
      d.chain = '0;
    end
    return d;
  endfunction : decode

  // ****************************************
  // Register bus
  // ****************************************

  logic [7:0] decim_control;
  logic [7:0] converter_input_select;
  logic [7:0] nco_channel_control;
  logic [7:0] chan_select;
  logic       ack;
  logic [7:0] next_decim_control;
  logic [7:0] next_input_select;
  logic [7:0] next_osc_control;
  logic [7:0] next_chan_select;
  logic       next_ack;
  logic [31:0] next_readdata;
  logic       wr_go;
  logic       osc_wr;
  logic [11:0] idx;
  logic [3:0] count;

  assign idx         = {2'b00, address[11:2]};
  assign waitrequest = (read | write) & ~ack;
  assign wr_go       = write & ack & byteenable[0];
  assign osc_wr      = wr_go && (idx == `DNC_IDX_OSC_CTRL);

  // Each access waits one cycle so read data comes from a flop
  always_comb
  begin
    next_ack           = (read | write) & ~ack;
    next_decim_control = decim_control;
    next_input_select  = converter_input_select;
    next_osc_control   = nco_channel_control;
    next_chan_select   = chan_select;
    next_readdata      = readdata;
    if (wr_go)
    begin
      unique case (idx)
        `DNC_IDX_DECIM_CTRL: next_decim_control = writedata[7:0];
        `DNC_IDX_INPUT_SEL:  next_input_select  = writedata[7:0] & `DNC_INPUT_SEL_MASK;
        `DNC_IDX_OSC_CTRL:   next_osc_control   = writedata[7:0];
        `DNC_IDX_CHAN_SEL:   next_chan_select   = {4'h0, writedata[3:0]};
        default: ;
      endcase
    end
    if (read && !ack)
    begin
      unique case (idx)
        `DNC_IDX_DECIM_CTRL: next_readdata = {24'h0, decim_control};
        `DNC_IDX_INPUT_SEL:  next_readdata = {24'h0, converter_input_select};
        `DNC_IDX_OSC_CTRL:   next_readdata = {24'h0, nco_channel_control};
        `DNC_IDX_CHAN_SEL:   next_readdata = {24'h0, chan_select};
        `DNC_IDX_STATUS:     next_readdata = {10'h000, decim_cfg, count, active_channel};
        default:             next_readdata = 32'h0; // Unmapped reads as zero
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ack                    <= 1'b0;
      decim_control          <= `DNC_RST_DECIM_CTRL;
      converter_input_select <= `DNC_RST_INPUT_SEL;
      nco_channel_control    <= `DNC_RST_OSC_CTRL;
      chan_select            <= `DNC_RST_CHAN_SEL;
      readdata               <= 32'h0;
    end
    else
    begin
      ack                    <= next_ack;
      decim_control          <= next_decim_control;
      converter_input_select <= next_input_select;
      nco_channel_control    <= next_osc_control;
      chan_select            <= next_chan_select;
      readdata               <= next_readdata;
    end
  end

  // ****************************************
  // Pin synchroniser
  // ****************************************

  logic [3:0] s1;
  logic [3:0] s2;
  logic [3:0] s3;
  logic [3:0] pins;
  logic [3:0] next_pins;

  // level accepted only when stages two and three agree
  always_comb
  begin
    next_pins = pins;
    for (int i = 0; i < 4; i++)
    begin
      if (s2[i] == s3[i])
      begin
        next_pins[i] = s3[i];
      end
    end
  end

  // Bit order: {b1, b0, a1, a0}
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1   <= 4'h0;
      s2   <= 4'h0;
      s3   <= 4'h0;
      pins <= 4'h0;
    end
    else
    begin
      s1   <= {select_pin_b_bit1, select_pin_b_bit0, select_pin_a_bit1, select_pin_a_bit0};
      s2   <= s1;
      s3   <= s2;
      pins <= next_pins;
    end
  end

  // ****************************************
  // Index selection and edge counter
  // ****************************************

  dnc_pkg::dnc_mode_e  mode;
  dnc_pkg::dnc_decim_s next_decim;
  logic [3:0] limit;
  logic       edge_hit;
  logic [3:0] next_count;
  logic [3:0] next_chan;

  assign mode  = dnc_pkg::dnc_mode_e'(nco_channel_control[7:4]);
  assign limit = nco_channel_control[3:0];

  // Counter clear beats a coincident edge, the mode is being changed anyway
  always_comb
  begin
    edge_hit   = 1'b0;
    next_count = count;
    next_chan  = 4'h0;
    unique case (mode)
      dnc_pkg::DNC_MODE_REG:  next_chan = chan_select[3:0];
      dnc_pkg::DNC_MODE_B0A0: next_chan = {2'b00, pins[2], pins[0]};
      dnc_pkg::DNC_MODE_B1A1: next_chan = {2'b00, pins[3], pins[1]};
      dnc_pkg::DNC_MODE_A1A0: next_chan = {2'b00, pins[1], pins[0]};
      dnc_pkg::DNC_MODE_B1B0: next_chan = {2'b00, pins[3], pins[2]};
      dnc_pkg::DNC_MODE_MIXA: next_chan = {pins[3], pins[1], pins[2], pins[0]};
      dnc_pkg::DNC_MODE_MIXB: next_chan = pins;
      dnc_pkg::DNC_MODE_EA0:  begin edge_hit = next_pins[0] & ~pins[0]; next_chan = count; end
      dnc_pkg::DNC_MODE_EA1:  begin edge_hit = next_pins[1] & ~pins[1]; next_chan = count; end
      dnc_pkg::DNC_MODE_EB0:  begin edge_hit = next_pins[2] & ~pins[2]; next_chan = count; end
      default:                next_chan = 4'h0; // Unused codes park on channel 0
    endcase
    if (edge_hit)
    begin
      next_count = (count >= limit) ? 4'h0 : count + 4'h1;
    end
    if (osc_wr)
    begin
      next_count = 4'h0;
    end
    next_decim = decode(decim_control[2:0], converter_input_select[7:4],
                        decim_control[`DNC_BIT_C2R]);
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      count               <= 4'h0;
      active_channel      <= 4'h0;
      decim_cfg           <= '0;
      real_output         <= 1'b0;
      quad_path_source    <= 1'b1;
      inphase_path_source <= 1'b1;
    end
    else
    begin
      count               <= next_count;
      active_channel      <= next_chan;
      decim_cfg           <= next_decim;
      real_output         <= decim_control[`DNC_BIT_C2R];
      quad_path_source    <= converter_input_select[`DNC_BIT_QSRC];
      inphase_path_source <= converter_input_select[`DNC_BIT_ISRC];
    end
  end

  // ****************************************
  // Assertions
  // ****************************************

  property p_ext0;
    @(posedge clock) disable iff (!arst_n)
    (decim_control[2:0] == 3'h7 && converter_input_select[7:4] == 4'h0 && !decim_control[3])
    |=> (decim_cfg.factor == 6'h30 && decim_cfg.chain == 7'h2F);
  endproperty
  a_ext0: assert property (p_ext0) else $error("ext code 0 wrong");

  property p_ext2;
    @(posedge clock) disable iff (!arst_n)
    (decim_control[2:0] == 3'h7 && converter_input_select[7:4] == 4'h2 && decim_control[3])
    |=> (decim_cfg.factor == 6'h05 && decim_cfg.chain.fifth_band_stage && decim_cfg.chain.half_band_stage_one);
  endproperty
  a_ext2: assert property (p_ext2) else $error("ext code 2 real wrong");

  property p_ext7;
    @(posedge clock) disable iff (!arst_n)
    (decim_control[2:0] == 3'h7 && converter_input_select[7:4] == 4'h7)
    |=> (decim_cfg.bad == $past(decim_control[3]));
  endproperty
  a_ext7: assert property (p_ext7) else $error("ext code 7 support wrong");

  property p_prim;
    @(posedge clock) disable iff (!arst_n)
    (decim_control[2:0] == 3'h0) |=> (decim_cfg.factor == (decim_control[3] ? 6'h02 : 6'h04));
  endproperty
  a_prim: assert property (p_prim) else $error("primary select ignored");

  property p_qsrc;
    @(posedge clock) disable iff (!arst_n)
    1'b1 |=> quad_path_source == $past(converter_input_select[2]);
  endproperty
  a_qsrc: assert property (p_qsrc) else $error("q source mismatch");

  property p_mode0;
    @(posedge clock) disable iff (!arst_n)
    (mode == dnc_pkg::DNC_MODE_REG) |=> active_channel == $past(chan_select[3:0]);
  endproperty
  a_mode0: assert property (p_mode0) else $error("mode 0 index wrong");

  property p_mode5;
    @(posedge clock) disable iff (!arst_n)
    (mode == dnc_pkg::DNC_MODE_MIXA) |=> active_channel == {$past(pins[3]), $past(pins[1]),
                                                            $past(pins[2]), $past(pins[0])};
  endproperty
  a_mode5: assert property (p_mode5) else $error("mode 5 order wrong");

  property p_wrap;
    @(posedge clock) disable iff (!arst_n)
    (edge_hit && !osc_wr && count == limit) |=> count == 4'h0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap");

  property p_clr;
    @(posedge clock) disable iff (!arst_n)
    osc_wr |=> count == 4'h0;
  endproperty
  a_clr: assert property (p_clr) else $error("counter not cleared");

  property p_once;
    @(posedge clock) disable iff (!arst_n)
    (!edge_hit && !osc_wr) |=> $stable(count);
  endproperty
  a_once: assert property (p_once) else $error("count moved without edge");

  c_wrap: cover property (@(posedge clock) edge_hit && count == limit);
  c_ext9: cover property (@(posedge clock) decim_cfg.factor == 6'h1E);
  c_mode6: cover property (@(posedge clock) mode == dnc_pkg::DNC_MODE_MIXB && pins == 4'hF);

endmodule : dnc_top

// >>> verif/dnc_pin_driver.sv
// Far-side model that drives the four oscillator select pins
`timescale 1ns/10ps
module dnc_pin_driver (
  input  wire logic       clock,
  output logic      [3:0] pins
);
  // ****
  // Pin stimulus, vector is {b1, b0, a1, a0}
  // ****
  initial pins = 4'h0;

  task automatic set_pins(input logic [3:0] v);
    @(posedge clock);
    pins <= v;
  endtask : set_pins

  // whole edge pulse
  // Three clocks high and low, so the synchroniser sees one clean edge
  task automatic pulse(input int idx);
    @(posedge clock);
    pins[idx] <= 1'b1;
    repeat (3) @(posedge clock);
    pins[idx] <= 1'b0;
    repeat (3) @(posedge clock);
  endtask : pulse
endmodule : dnc_pin_driver

// >>> verif/tb_top.sv
// Self-checking bench for the down-converter config block
`timescale 1ns/10ps
module tb_top;
  logic                clock;
  logic                arst_n;
  logic [11:0]         address;
  logic                read;
  logic                write;
  logic [3:0]          byteenable;
  logic [31:0]         writedata;
  logic [31:0]         readdata;
  logic                waitrequest;
  logic [3:0]          pins;
  logic [3:0]          active_channel;
  dnc_pkg::dnc_decim_s decim_cfg;
  logic                real_output;
  logic                quad_path_source;
  logic                inphase_path_source;
  logic                look_en;
  logic [1:0]          look_sel;
  logic [31:0]         obs;
  logic [31:0]         exp_q[$];
  logic [31:0]         rnd;
  logic [14:0]         ev;
  int                  fail_count;
  int                  checks_done;
  int                  seed;
  // Chain and factor for extended codes 0,2,3,4,7,8,9
  logic [3:0]          cd_t[7] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'h9};
  logic [6:0]          ch_t[7] = '{7'h2F, 7'h41, 7'h43, 7'h47, 7'h10, 7'h50, 7'h52};
  logic [5:0]          fa_t[7] = '{6'h30, 6'h0A, 6'h14, 6'h28, 6'h03, 6'h0F, 6'h1E};

  dnc_top dut (
    .clock(clock), .arst_n(arst_n), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .select_pin_a_bit0(pins[0]), .select_pin_a_bit1(pins[1]), .select_pin_b_bit0(pins[2]),
    .select_pin_b_bit1(pins[3]), .active_channel(active_channel), .decim_cfg(decim_cfg),
    .real_output(real_output), .quad_path_source(quad_path_source), .inphase_path_source(inphase_path_source)
  );

  dnc_pin_driver pd (
    .clock(clock),
    .pins(pins)
  );

  // ****
  // Shared tasks
  // ****
  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    checks_done++;
    if (seen !== expv)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask : check

  // Avalon request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clock);
    read       <= ~wr;
    write      <= wr;
    address    <= a;
    writedata  <= {24'($random(seed)), d};
    byteenable <= be;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) fail_count++;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 8'h00, 4'hF);
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask : wr

  // Asks the monitor to compare one level output group
  task automatic look(input logic [1:0] s, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge clock);
    look_en  <= 1'b1;
    look_sel <= s;
    @(posedge clock);
    look_en  <= 1'b0;
  endtask : look

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
  endtask : settle

  function automatic logic [3:0] pin_idx(input logic [3:0] m, input logic [3:0] p);
    case (m)
      4'h1: pin_idx = {2'h0, p[2], p[0]};
      4'h2: pin_idx = {2'h0, p[3], p[1]};
      4'h3: pin_idx = {2'h0, p[1], p[0]};
      4'h4: pin_idx = {2'h0, p[3], p[2]};
      4'h5: pin_idx = {p[3], p[1], p[2], p[0]};
      default: pin_idx = p;
    endcase
  endfunction : pin_idx

  task automatic tally_and_finish;
    if (fail_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  // ****
  // Clock, monitor, watchdog and main sequence
  // ****
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  assign obs = (look_sel == 2'h0) ? {28'h0, active_channel} :
               (look_sel == 2'h1) ? {17'h0, decim_cfg, real_output} :
               {30'h0, quad_path_source, inphase_path_source};

  // Oldest note is matched against each read answer or look request
  always @(posedge clock)
  begin
    if (read && waitrequest === 1'b0) check(readdata, exp_q.pop_front());
    if (look_en) check(obs, exp_q.pop_front());
  end

  // Whole run needs under 2000 cycles; hang guard is generous
  initial
  begin
    repeat (5000) @(posedge clock);
    fail_count++;
    tally_and_finish();
  end

  initial
  begin
    seed = 32'h709e;
    arst_n = 1'b0; address = 12'h000; read = 1'b0; write = 1'b0;
    byteenable = 4'h0; writedata = 32'h0; look_en = 1'b0; look_sel = 2'h0;
    fail_count = 0; checks_done = 0;
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    look(2'h2, 32'h3);
    rd(12'hCC4, 32'h05);
    rd(12'hC50, 32'h0);
    wr(12'hCC4, 8'h00);
    settle(2);
    look(2'h2, 32'h0);
    bus(1'b1, 12'hCC4, 8'hFF, 4'h0);
    rd(12'hCC4, 32'h00);
    wr(12'hCC4, 8'hFF);
    rd(12'hCC4, 32'hF5);
    settle(1);
    look(2'h2, 32'h3);
    // Every supported extended code (0,2,3,4,7,8,9), both output kinds
    for (int i = 0; i < 7; i++)
      for (int r = 0; r < 2; r++)
      begin
        wr(12'hCC4, {cd_t[i], 4'h5});
        wr(12'hCC0, {4'h0, r[0], 3'h7});
        ev = {ch_t[i], (r == 1) ? (fa_t[i] >> 1) : fa_t[i], 1'b0, r[0]};
        if (r == 1 && i > 3) ev = {14'h0001, 1'b1};
        settle(2);
        look(2'h1, {17'h0, ev});
      end
    // Extended code must be ignored below primary 7
    wr(12'hCC0, 8'h00);
    settle(2);
    look(2'h1, {17'h0, 7'h03, 6'h04, 1'b0, 1'b0});
    rnd = $random(seed);
    wr(12'hC50, rnd[7:0]);
    rd(12'hC50, {28'h0, rnd[3:0]});
    wr(12'hCD0, 8'h00);
    settle(2);
    look(2'h0, {28'h0, rnd[3:0]});
    // Pin-built index, random pin patterns per mode
    for (int m = 1; m < 7; m++)
    begin
      wr(12'hCD0, {m[3:0], 4'h0});
      for (int k = 0; k < 3; k++)
      begin
        rnd = $random(seed);
        pd.set_pins(rnd[3:0]);
        settle(6);
        look(2'h0, {28'h0, pin_idx(m[3:0], rnd[3:0])});
      end
    end
    pd.set_pins(4'h0);
    settle(6);
    // Edge counting, wrap at limit 2, clear on rewrite
    for (int m = 8; m < 11; m++)
    begin
      wr(12'hCD0, {m[3:0], 4'h2});
      rd(12'hCD0, {24'h0, m[3:0], 4'h2});
      settle(2);
      look(2'h0, 32'h0);
      for (int k = 1; k < 4; k++)
      begin
        pd.pulse(m - 8);
        look(2'h0, k % 3);
      end
      pd.pulse(m - 8);
      look(2'h0, 32'h1);
      wr(12'hCD0, {m[3:0], 4'h2});
      settle(2);
      look(2'h0, 32'h0);
    end
    settle(4);
    // Status word: primary 0 decode, cleared counter, channel 0
    rd(12'hFC0, 32'h00018800);
    tally_and_finish();
  end
endmodule : tb_top
